// *** hpa_pkg.sv ***
// Shared constants for the host port access block and its host end
package hpa_pkg;
  localparam int CLK_NS     = 25;
  localparam int DATA_W     = 32;
  localparam int ADDR_W     = 8;
  localparam int GAP_W      = 5;
  // Bus timing in ns and derived cycle counts
  localparam int T_CSL_NS   = 32;
  localparam int T_CSH_NS   = 13;
  localparam int T_CYCLE_NS = 45;
  localparam int T_TXLVL_NS = 135;
  localparam int CSL_CYC    = (T_CSL_NS + CLK_NS - 1) / CLK_NS;
  localparam int CSH_CYC    = (T_CSH_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYCLE_CYC  = (T_CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int TXLVL_CYC  = (T_TXLVL_NS / CLK_NS < 1) ? 1 :
                              T_TXLVL_NS / CLK_NS;
  // Wait times before a read, in ns and in cycles
  localparam int W45_NS     = 45;
  localparam int W90_NS     = 90;
  localparam int W135_NS    = 135;
  localparam int W180_NS    = 180;
  localparam int W315_NS    = 315;
  localparam int W45_CYC    = (W45_NS + CLK_NS - 1) / CLK_NS;
  localparam int W90_CYC    = (W90_NS + CLK_NS - 1) / CLK_NS;
  localparam int W135_CYC   = (W135_NS + CLK_NS - 1) / CLK_NS;
  localparam int W180_CYC   = (W180_NS + CLK_NS - 1) / CLK_NS;
  localparam int W315_CYC   = (W315_NS + CLK_NS - 1) / CLK_NS;
  // Register byte offsets
  localparam logic [7:0] OFS_RX_DATA        = 8'h00;
  localparam logic [7:0] OFS_TX_DATA        = 8'h20;
  localparam logic [7:0] OFS_RX_STATUS      = 8'h40;
  localparam logic [7:0] OFS_TX_STATUS      = 8'h48;
  localparam logic [7:0] OFS_CHIP_IDENTITY  = 8'h50;
  localparam logic [7:0] OFS_IRQ_PIN_CFG    = 8'h54;
  localparam logic [7:0] OFS_INT_STATUS     = 8'h58;
  localparam logic [7:0] OFS_BYTE_ORDER     = 8'h64;
  localparam logic [7:0] OFS_HW_CONFIG      = 8'h74;
  localparam logic [7:0] OFS_RX_FIFO_LEVEL  = 8'h7C;
  localparam logic [7:0] OFS_TX_FIFO_LEVEL  = 8'h80;
  localparam logic [7:0] OFS_POWER_MGMT     = 8'h84;
  localparam logic [7:0] OFS_TIMER_COUNT    = 8'h90;
  localparam logic [7:0] OFS_FREE_RUN       = 8'h9C;
  localparam logic [7:0] OFS_RX_DROP        = 8'hA0;
  // Reset values
  localparam logic [31:0] HW_CONFIG_RST     = 32'h0000_0000;
  typedef logic [GAP_W-1:0] hpa_gap_type;
endpackage : hpa_pkg

// *** hpa_if.sv ***
// Pin bundle between the host end and the device end
`timescale 1ns/1ps
interface hpa_if;
  logic        chip_select_low;
  logic        read_strobe_low;
  logic        write_strobe_low;
  logic        fifo_sel;
  logic [7:0]  addr;
  logic [31:0] host_dq;
  logic        host_dq_oe;
  logic [31:0] dev_dq;
  logic        dev_dq_oe_lo;
  logic        dev_dq_oe_hi;
  logic [31:0] dq;
  // Undriven lanes read as zero in place of a floating bus
  assign dq[15:0]  = host_dq_oe ? host_dq[15:0] :
                     dev_dq_oe_lo ? dev_dq[15:0] : 16'h0000;
  assign dq[31:16] = host_dq_oe ? host_dq[31:16] :
                     dev_dq_oe_hi ? dev_dq[31:16] : 16'h0000;
  modport host (output chip_select_low, read_strobe_low,
                write_strobe_low, fifo_sel, addr, host_dq,
                host_dq_oe, input dq);
  modport dev  (input chip_select_low, read_strobe_low,
                write_strobe_low, fifo_sel, addr, dq,
                output dev_dq, dev_dq_oe_lo, dev_dq_oe_hi);
endinterface : hpa_if

// *** hpa_fifo.sv ***
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module hpa_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  // Drain side
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  // Fill level
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } hpa_fifo_st_type;
  hpa_fifo_st_type st;
  hpa_fifo_st_type next_st;
  logic push;
  logic pop;

  always_comb begin
    in_ready_o  = st.cnt != (AW+1)'(DEPTH);
    out_valid_o = st.cnt != '0;
    out_data_o  = st.mem[st.rp];
    count_o     = st.cnt;
    push        = in_valid_i & in_ready_o;
    pop         = out_valid_o & out_ready_i;
    next_st     = st;
    if (push) begin
      next_st.mem[st.wp] = in_data_i;
      next_st.wp         = st.wp + 1'b1;
    end
    if (pop) begin
      next_st.rp = st.rp + 1'b1;
    end
    next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : hpa_fifo

// *** hpa_device.sv ***
// Device end: register and FIFO access over the asynchronous host port
`timescale 1ns/1ps
module hpa_device
  import hpa_pkg::*;
#(
  parameter logic [31:0] CHIP_IDENTITY = 32'h0123_0001, // Arbitrary
  parameter logic [31:0] BYTE_ORDER    = 32'h1357_9BDF, // Arbitrary
  parameter int          TX_DEPTH      = 4
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // Host port pins
  hpa_if.dev               bus,
  // Bus width strap, high for 16-bit
  input  wire logic        bus16_i,
  // Receive data and status streams
  input  wire logic [31:0] rx_data_i,
  input  wire logic        rx_data_valid_i,
  output logic             rx_data_ready_o,
  input  wire logic [31:0] rx_status_i,
  input  wire logic        rx_status_valid_i,
  output logic             rx_status_ready_o,
  input  wire logic [15:0] rx_level_i,
  input  wire logic        rx_drop_i,
  // Transmit status stream
  input  wire logic [31:0] tx_status_i,
  input  wire logic        tx_status_valid_i,
  output logic             tx_status_ready_o,
  // Transmit data stream
  output logic [31:0]      tx_data_o,
  output logic             tx_data_valid_o,
  input  wire logic        tx_data_ready_i,
  // Configuration
  output logic [31:0]      hw_config_o
);
  localparam int CW = $clog2(TX_DEPTH) + 1;
  typedef struct packed {
    logic        rd_act;
    logic        wr_act;
    logic [31:0] rdata;
    logic [31:0] wdata;
    logic [7:0]  waddr;
    logic        wfifo;
    logic        wpend;
    logic [31:0] hardware_config_reg;
    logic [31:0] free_run;
    logic [31:0] rx_drop;
    logic [CW-1:0] tx_lvl;
    logic [3:0]  lvl_dly;
  } hpa_dev_st_type;
  hpa_dev_st_type st;
  hpa_dev_st_type next_st;
  logic          rd_now;
  logic          wr_now;
  logic          rd_start;
  logic          wr_end;
  logic [7:0]    a;
  logic          tx_push;
  logic          tx_ready;
  logic [CW-1:0] tx_cnt;

  hpa_fifo #(.WIDTH(32), .DEPTH(TX_DEPTH)) u_tx_fifo (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_data_i   (st.wdata),
    .in_valid_i  (tx_push),
    .in_ready_o  (tx_ready),
    .out_data_o  (tx_data_o),
    .out_valid_o (tx_data_valid_o),
    .out_ready_i (tx_data_ready_i),
    .count_o     (tx_cnt)
  );

  always_comb begin
    rd_now   = ~bus.chip_select_low & ~bus.read_strobe_low;
    wr_now   = ~bus.chip_select_low & ~bus.write_strobe_low;
    rd_start = rd_now & ~st.rd_act;
    wr_end   = st.wr_act & ~wr_now;
    a        = bus.fifo_sel ? OFS_RX_DATA : bus.addr;
    next_st  = st;
    rx_data_ready_o   = 1'b0;
    rx_status_ready_o = 1'b0;
    tx_status_ready_o = 1'b0;
    tx_push  = st.wpend & st.wfifo;
    next_st.rd_act   = rd_now;
    next_st.wr_act   = wr_now;
    next_st.free_run = st.free_run + 32'h0000_0001;
    // Level shows the new count only after the settle delay
    if (st.lvl_dly != '0) begin
      next_st.lvl_dly = st.lvl_dly - 4'h1;
    end else begin
      next_st.tx_lvl = tx_cnt;
    end
    // Read data and side effects happen once, at the cycle start
    if (rd_start) begin
      unique case (a)
        OFS_RX_DATA: begin
          next_st.rdata   = rx_data_valid_i ? rx_data_i : '0;
          rx_data_ready_o = rx_data_valid_i;
        end
        OFS_RX_STATUS: begin
          next_st.rdata     = rx_status_valid_i ? rx_status_i : '0;
          rx_status_ready_o = rx_status_valid_i;
        end
        OFS_TX_STATUS: begin
          next_st.rdata     = tx_status_valid_i ? tx_status_i : '0;
          tx_status_ready_o = tx_status_valid_i;
        end
        OFS_CHIP_IDENTITY: next_st.rdata = CHIP_IDENTITY;
        OFS_BYTE_ORDER:    next_st.rdata = BYTE_ORDER;
        OFS_HW_CONFIG:     next_st.rdata = st.hardware_config_reg;
        OFS_RX_FIFO_LEVEL: next_st.rdata = {16'h0000, rx_level_i};
        OFS_TX_FIFO_LEVEL: next_st.rdata = 32'(st.tx_lvl);
        OFS_FREE_RUN:      next_st.rdata = st.free_run;
        OFS_RX_DROP: begin
          next_st.rdata   = st.rx_drop;
          next_st.rx_drop = '0;
        end
        default:           next_st.rdata = '0;
      endcase
    end
    // A drop in the clearing cycle is still counted
    if (rx_drop_i) begin
      next_st.rx_drop = (rd_start && a == OFS_RX_DROP) ?
                        32'h0000_0001 : st.rx_drop + 32'h0000_0001;
    end
    // Data is sampled each cycle and committed at the cycle end
    if (wr_now) begin
      next_st.wdata = bus16_i ? {16'h0000, bus.dq[15:0]} : bus.dq;
      next_st.waddr = bus.addr;
    end
    if (tx_push && tx_ready) begin
      next_st.wpend   = 1'b0;
      next_st.lvl_dly = 4'(TXLVL_CYC);
    end
    if (wr_end) begin
      if (st.waddr == OFS_HW_CONFIG) begin
        next_st.hardware_config_reg = st.wdata;
      end
      // A full FIFO holds the word here until space frees
      next_st.wpend = st.waddr == OFS_TX_DATA;
      next_st.wfifo = st.waddr == OFS_TX_DATA;
    end
  end

  always_comb begin
    bus.dev_dq       = st.rdata;
    bus.dev_dq_oe_lo = st.rd_act & rd_now;
    bus.dev_dq_oe_hi = st.rd_act & rd_now & ~bus16_i;
    hw_config_o      = st.hardware_config_reg;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st        <= '0;
      st.hardware_config_reg <= HW_CONFIG_RST;
    end else begin
      st <= next_st;
    end
  end
endmodule : hpa_device

// *** hpa_host.sv ***
// Host end: paces reads and writes on the asynchronous host port
//
// How it works
// - Device supports plain and direct reads, plain writes
// - Transmit level settles up to 135 ns after write
// - Host waits a per-register time after writes
// - 135, 180, 315 ns waits for slow registers
// - 90 ns interrupt status, 45 ns others; no wait for ID, byte order, RX level, drop
// - Probe reads of byte order may fill waits
// - Fewer probes suffice when elapsed time suffices
// - Wait 135 ns after receive FIFO reads
// - Transmit status 135 ns; drop counter 180 ns
// - Reads reach registers and receive/transmit FIFOs
// - Counters captured at start of read cycle
// - Upper lanes undriven in 16-bit reads
// - Read starts with select and strobe low
// - Cycle ends when select or strobe goes high
// - Host raises a strobe between cycles
// - Cycle starts at least 45 ns apart
// - Upper lanes ignored in 16-bit writes
`timescale 1ns/1ps
module hpa_host
  import hpa_pkg::*;
#(
  parameter bit USE_PROBES = 1'b0
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // Host port pins
  hpa_if.host              bus,
  // Bus width, high for 16-bit
  input  wire logic        bus16_i,
  // Command port
  input  wire logic        cmd_valid_i,
  output logic             cmd_ready_o,
  input  wire logic        cmd_write_i,
  input  wire logic        cmd_fifo_sel_i,
  input  wire logic [7:0]  cmd_addr_i,
  input  wire logic [31:0] cmd_wdata_i,
  // Answer port
  output logic             rsp_valid_o,
  output logic [31:0]      rsp_data_o
);
  typedef enum logic [1:0] {
    HS_IDLE   = 2'b00,
    HS_WAIT   = 2'b01,
    HS_ACTIVE = 2'b10,
    HS_HIGH   = 2'b11
  } hpa_host_state_type;

  typedef struct packed {
    hpa_host_state_type state;
    logic [3:0]   cnt;
    hpa_gap_type  since_wr;
    hpa_gap_type  since_rx;
    hpa_gap_type  since_txs;
    hpa_gap_type  since_drop;
    hpa_gap_type  since_start;
    logic         write;
    logic         fsel;
    logic         probe;
    logic [7:0]   addr;
    logic [31:0]  wdata;
    logic [31:0]  rdata;
    logic         rsp;
  } hpa_host_st_type;

  hpa_host_st_type st;
  hpa_host_st_type next_st;
  hpa_gap_type     need_wr;
  hpa_gap_type     need_rd;
  logic            gap_ok;
  logic            start_ok;
  logic [7:0]      eff_addr;

  // Wait needed after a write, by the register about to be read
  always_comb begin
    eff_addr = st.fsel ? OFS_RX_DATA : st.addr;
    unique case (eff_addr)
      OFS_CHIP_IDENTITY,
      OFS_BYTE_ORDER,
      OFS_RX_FIFO_LEVEL,
      OFS_RX_DROP:       need_wr = '0;
      OFS_IRQ_PIN_CFG,
      OFS_TX_FIFO_LEVEL,
      OFS_TIMER_COUNT:   need_wr = GAP_W'(W135_CYC);
      OFS_FREE_RUN:      need_wr = GAP_W'(W180_CYC);
      OFS_POWER_MGMT:    need_wr = GAP_W'(W315_CYC);
      OFS_INT_STATUS:    need_wr = GAP_W'(W90_CYC);
      default:           need_wr = GAP_W'(W45_CYC);
    endcase
  end

  // Gap checks; writes and probes only need the cycle spacing
  always_comb begin
    need_rd = '0;
    gap_ok  = 1'b1;
    if (!st.write && !st.probe) begin
      gap_ok = st.since_wr >= need_wr;
      if (eff_addr == OFS_RX_FIFO_LEVEL) begin
        gap_ok = gap_ok &&
                 st.since_rx >= GAP_W'(W135_CYC);
      end
      if (eff_addr == OFS_TX_FIFO_LEVEL) begin
        gap_ok = gap_ok &&
                 st.since_txs >= GAP_W'(W135_CYC);
      end
      if (eff_addr == OFS_RX_DROP) begin
        need_rd = GAP_W'(W180_CYC);
        gap_ok  = gap_ok && st.since_drop >= need_rd;
      end
    end
    start_ok = st.since_start >= GAP_W'(CYCLE_CYC);
  end

  always_comb begin
    next_st     = st;
    next_st.rsp = 1'b0;
    // Elapsed-time counters saturate rather than wrap
    if (st.since_wr != '1) begin
      next_st.since_wr = st.since_wr + 1'b1;
    end
    if (st.since_rx != '1) begin
      next_st.since_rx = st.since_rx + 1'b1;
    end
    if (st.since_txs != '1) begin
      next_st.since_txs = st.since_txs + 1'b1;
    end
    if (st.since_drop != '1) begin
      next_st.since_drop = st.since_drop + 1'b1;
    end
    if (st.since_start != '1) begin
      next_st.since_start = st.since_start + 1'b1;
    end
    case (st.state)
      HS_IDLE: begin
        if (cmd_valid_i) begin
          next_st.write = cmd_write_i;
          next_st.fsel  = cmd_fifo_sel_i & ~cmd_write_i;
          next_st.addr  = cmd_addr_i;
          next_st.wdata = bus16_i ? {16'h0000, cmd_wdata_i[15:0]} :
                          cmd_wdata_i;
          next_st.probe = 1'b0;
          next_st.state = HS_WAIT;
        end
      end
      HS_WAIT: begin
        if (start_ok && gap_ok) begin
          next_st.state       = HS_ACTIVE;
          next_st.cnt         = 4'(CSL_CYC);
          next_st.since_start = '0;
        end else if (start_ok && USE_PROBES) begin
          // Probe reads let time pass with bus traffic
          next_st.probe       = 1'b1;
          next_st.state       = HS_ACTIVE;
          next_st.cnt         = 4'(CSL_CYC);
          next_st.since_start = '0;
        end
      end
      HS_ACTIVE: begin
        next_st.cnt = st.cnt - 4'h1;
        if (st.cnt == 4'h1) begin
          // Data is taken on the last low cycle of the strobe
          next_st.rdata = bus16_i ? {16'h0000, bus.dq[15:0]} :
                          bus.dq;
          next_st.state = HS_HIGH;
          next_st.cnt   = 4'(CSH_CYC);
          if (st.write) begin
            next_st.since_wr = '0;
          end else if (!st.probe) begin
            if (eff_addr == OFS_RX_DATA ||
                eff_addr == OFS_RX_STATUS) begin
              next_st.since_rx = '0;
            end
            if (eff_addr == OFS_TX_STATUS) begin
              next_st.since_txs = '0;
            end
            if (eff_addr == OFS_RX_DROP) begin
              next_st.since_drop = '0;
            end
          end
        end
      end
      HS_HIGH: begin
        next_st.cnt = st.cnt - 4'h1;
        if (st.cnt == 4'h1) begin
          if (st.probe) begin
            // Elapsed time is rechecked after every probe
            next_st.probe = 1'b0;
            next_st.state = HS_WAIT;
          end else begin
            next_st.rsp   = 1'b1;
            next_st.state = HS_IDLE;
          end
        end
      end
      default: begin
        next_st.state = HS_IDLE;
      end
    endcase
  end

  always_comb begin
    cmd_ready_o          = st.state == HS_IDLE;
    rsp_valid_o          = st.rsp;
    rsp_data_o           = st.rdata;
    bus.chip_select_low  = st.state != HS_ACTIVE;
    bus.read_strobe_low  = ~(st.state == HS_ACTIVE &
                             (~st.write | st.probe));
    bus.write_strobe_low = ~(st.state == HS_ACTIVE &
                             st.write & ~st.probe);
    bus.fifo_sel         = st.fsel & ~st.probe;
    bus.addr             = st.probe ? OFS_BYTE_ORDER : st.addr;
    bus.host_dq          = st.wdata;
    bus.host_dq_oe       = st.state == HS_ACTIVE & st.write &
                           ~st.probe;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st             <= '0;
      st.state       <= HS_IDLE;
      st.since_wr    <= '1;
      st.since_rx    <= '1;
      st.since_txs   <= '1;
      st.since_drop  <= '1;
      st.since_start <= '1;
    end else begin
      st <= next_st;
    end
  end
endmodule : hpa_host

// *** hpa_link_sva.sv ***
// Checker for the pin link between the host end and the device end
`timescale 1ns/1ps
module hpa_link_sva (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  // Pin link
  input wire logic        chip_select_low,
  input wire logic        read_strobe_low,
  input wire logic        write_strobe_low,
  input wire logic        fifo_sel,
  input wire logic [7:0]  addr,
  input wire logic        host_dq_oe,
  input wire logic [31:0] dev_dq,
  input wire logic        dev_dq_oe_lo,
  input wire logic        dev_dq_oe_hi
);
  logic rd_low;
  logic wr_low;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  assign rd_low = !chip_select_low && !read_strobe_low;
  assign wr_low = !chip_select_low && !write_strobe_low;

  rd_drive_only_a: assert property (dev_dq_oe_lo |-> rd_low)
    else $error("device drives outside a read cycle");
  rd_answer_a: assert property (rd_low && !$past(rd_low) |=> dev_dq_oe_lo)
    else $error("device silent after read start");
  rd_shape_a: assert property (rd_low && !$past(rd_low) |-> ##1 rd_low ##1 !rd_low)
    else $error("read low phase or release wrong");
  upper_lane_a: assert property (dev_dq_oe_hi |-> dev_dq_oe_lo)
    else $error("upper lanes driven alone");
  wr_drive_a: assert property (wr_low |-> host_dq_oe && !dev_dq_oe_lo)
    else $error("write data not driven by host");
  one_kind_a: assert property (!(rd_low && !write_strobe_low))
    else $error("read and write strobes low together");
  addr_steady_a: assert property (
    rd_low && $past(rd_low) |-> $stable(addr) && $stable(fifo_sel))
    else $error("address moved inside a read");
  rdata_steady_a: assert property (
    dev_dq_oe_lo && $past(dev_dq_oe_lo) |-> $stable(dev_dq))
    else $error("read data moved inside a read");

  cover property (rd_low && fifo_sel);
  cover property (wr_low);
  cover property (dev_dq_oe_hi);
endmodule : hpa_link_sva

// *** tb.sv ***
// Testbench joining host end and device end across the pin bundle
`timescale 1ns/1ps
module tb;
  import hpa_pkg::*;
  localparam logic [31:0] CHIP_ID  = 32'h0BAD_0002; // Arbitrary value
  localparam logic [31:0] ORDER_ID = 32'h2468_ACE0; // Arbitrary value
  logic        clk_i          = 1'b0;
  logic        sys_rst_i      = 1'b1;
  logic        bus16_i        = 1'b0;
  logic        cmd_valid_i    = 1'b0;
  logic        cmd_write_i    = 1'b0;
  logic        cmd_fifo_sel_i = 1'b0;
  logic [7:0]  cmd_addr_i     = 8'h00;
  logic [31:0] cmd_wdata_i    = 32'h0000_0000;
  logic        tx_data_ready_i = 1'b0;
  logic        rx_drop_i      = 1'b0;
  logic        cmd_ready_o;
  logic        rsp_valid_o;
  logic [31:0] rsp_data_o;
  logic [31:0] hw_config_o;
  logic [31:0] tx_data_o;
  logic        tx_data_valid_o;
  logic        rx_data_ready_o;
  logic        rx_status_ready_o;
  logic        tx_status_ready_o;
  logic [2:0]  pop            = 3'b000;
  logic [7:0]  cnt [3]        = '{default: 8'h00};
  logic [7:0]  lim [3]        = '{default: 8'h00};
  logic [31:0] txq [$];
  logic [31:0] q;
  int          fail_count     = 0;
  int          checks_done    = 0;

  always #12.5 clk_i = ~clk_i;

  hpa_if hpa_if_i ();
  hpa_host hpa_host_i (.clk_i, .sys_rst_i, .bus(hpa_if_i), .bus16_i,
    .cmd_valid_i, .cmd_ready_o, .cmd_write_i, .cmd_fifo_sel_i, .cmd_addr_i,
    .cmd_wdata_i, .rsp_valid_o, .rsp_data_o);
  hpa_device #(.CHIP_IDENTITY(CHIP_ID), .BYTE_ORDER(ORDER_ID)) hpa_device_i (
    .clk_i, .sys_rst_i, .bus(hpa_if_i), .bus16_i,
    .rx_data_i({24'hDA_0000, cnt[0]}), .rx_data_valid_i(cnt[0] < lim[0]),
    .rx_data_ready_o, .rx_status_i({24'h5A_0000, cnt[1]}),
    .rx_status_valid_i(cnt[1] < lim[1]), .rx_status_ready_o,
    .rx_level_i(16'h0123), .rx_drop_i,
    .tx_status_i({24'h7E_0000, cnt[2]}), .tx_status_valid_i(cnt[2] < lim[2]),
    .tx_status_ready_o, .tx_data_o, .tx_data_valid_o, .tx_data_ready_i,
    .hw_config_o);
  hpa_link_sva hpa_link_sva_i (.clk_i, .sys_rst_i,
    .chip_select_low(hpa_if_i.chip_select_low),
    .read_strobe_low(hpa_if_i.read_strobe_low),
    .write_strobe_low(hpa_if_i.write_strobe_low),
    .fifo_sel(hpa_if_i.fifo_sel), .addr(hpa_if_i.addr),
    .host_dq_oe(hpa_if_i.host_dq_oe), .dev_dq(hpa_if_i.dev_dq),
    .dev_dq_oe_lo(hpa_if_i.dev_dq_oe_lo),
    .dev_dq_oe_hi(hpa_if_i.dev_dq_oe_hi));

  // Pops are seen at the rising edge, streams advance at the falling edge
  always @(posedge clk_i) begin
    pop <= {tx_status_ready_o, rx_status_ready_o, rx_data_ready_o};
    if (tx_data_valid_o === 1'b1 && tx_data_ready_i)
      txq.push_back(tx_data_o);
  end
  always @(negedge clk_i)
    for (int k = 0; k < 3; k++)
      if (pop[k] === 1'b1)
        cnt[k] <= cnt[k] + 8'h01;

  task automatic complete_run;
    if (fail_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chkb(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chkb

  // One command through the host end; answer lands in q
  task automatic xfer(input logic w, input logic f, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    @(negedge clk_i);
    cmd_valid_i    = 1'b1;
    cmd_write_i    = w;
    cmd_fifo_sel_i = f;
    cmd_addr_i     = a;
    cmd_wdata_i    = d;
    while (cmd_ready_o !== 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    @(negedge clk_i);
    cmd_valid_i = 1'b0;
    while (rsp_valid_o !== 1'b1 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    chkb(rsp_valid_o, 1'b1);
    q = rsp_data_o;
  endtask : xfer

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, 1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask : rd

  task automatic t_regs;
    chk(hw_config_o, HW_CONFIG_RST);
    chkb(tx_data_valid_o, 1'b0);
    rd(OFS_CHIP_IDENTITY, CHIP_ID);
    rd(OFS_BYTE_ORDER, ORDER_ID);
    rd(8'hF0, 32'h0000_0000);
    rd(OFS_RX_FIFO_LEVEL, 32'h0000_0123);
  endtask : t_regs

  task automatic t_config;
    xfer(1'b1, 1'b0, OFS_HW_CONFIG, 32'hCAFE_1234);
    chk(hw_config_o, 32'hCAFE_1234);
    rd(OFS_HW_CONFIG, 32'hCAFE_1234);
    bus16_i = 1'b1;
    xfer(1'b1, 1'b0, OFS_HW_CONFIG, 32'h5555_AAAA);
    chk(hw_config_o, 32'h0000_AAAA);
    rd(OFS_HW_CONFIG, 32'h0000_AAAA);
    bus16_i = 1'b0;
  endtask : t_config

  task automatic t_rx;
    lim[0] = 8'h02;
    rd(OFS_RX_DATA, 32'hDA00_0000);
    rd(OFS_RX_DATA, 32'hDA00_0001);
    rd(OFS_RX_DATA, 32'h0000_0000);
    lim[0] = 8'h03;
    xfer(1'b0, 1'b1, OFS_CHIP_IDENTITY, 32'h0000_0000);
    chk(q, 32'hDA00_0002);
    lim[1] = 8'h01;
    lim[2] = 8'h01;
    rd(OFS_RX_STATUS, 32'h5A00_0000);
    rd(OFS_TX_STATUS, 32'h7E00_0000);
    chk({8'h00, cnt[2], cnt[1], cnt[0]}, 32'h0001_0103);
  endtask : t_rx

  task automatic t_drop;
    repeat (3) begin
      @(negedge clk_i);
      rx_drop_i = 1'b1;
      @(negedge clk_i);
      rx_drop_i = 1'b0;
    end
    rd(OFS_RX_DROP, 32'h0000_0003);
    rd(OFS_RX_DROP, 32'h0000_0000);
  endtask : t_drop

  // Far side stalls while four words fill the buffer and a fifth waits
  task automatic t_tx;
    for (int k = 0; k < 5; k++)
      xfer(1'b1, 1'b0, OFS_TX_DATA, 32'hB0B0_0000 + 32'(k));
    chkb(tx_data_valid_o, 1'b1);
    chk(32'(txq.size()), 32'h0000_0000);
    rd(OFS_TX_FIFO_LEVEL, 32'h0000_0004);
    tx_data_ready_i = 1'b1;
    repeat (20) @(negedge clk_i);
    rd(OFS_TX_FIFO_LEVEL, 32'h0000_0000);
    chk(32'(txq.size()), 32'h0000_0005);
    foreach (txq[k])
      chk(txq[k], 32'hB0B0_0000 + 32'(k));
    chkb(tx_data_valid_o, 1'b0);
  endtask : t_tx

  initial begin
    repeat (6) @(negedge clk_i);
    sys_rst_i = 1'b0;
    t_regs();
    t_config();
    t_rx();
    t_drop();
    t_tx();
    complete_run();
  end

  // About 23 commands of under a dozen cycles each fit well inside this span
  initial begin
    #100000;
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end
endmodule : tb
